/* File: src/sic_pkg.sv */
// Shared constants and types for the SDRAM init and configuration pair
package sic_pkg;
    // Clock and documented wait figures
    localparam int CLK_PERIOD_PS = 5000;
    localparam int POWERUP_NS = 100000;
    localparam int TRP_NS = 20;
    localparam int REFRESH_CYCLE_TIME_NS = 70;
    localparam int CONFIG_LOAD_DELAY_NS = 10;
    // Least waits round up to whole cycles; those after a command never below two
    localparam int POWERUP_CYCLES = (POWERUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRP_CYC_RAW = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REFRESH_CYCLE_TIME_CYC_RAW = (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CONFIG_LOAD_DELAY_CYC_RAW = (CONFIG_LOAD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRP_CYC = (TRP_CYC_RAW < 2) ? 2 : TRP_CYC_RAW;
    localparam int REFRESH_CYCLE_TIME_CYC = (REFRESH_CYCLE_TIME_CYC_RAW < 2) ? 2 : REFRESH_CYCLE_TIME_CYC_RAW;
    localparam int CONFIG_LOAD_DELAY_CYC = (CONFIG_LOAD_DELAY_CYC_RAW < 2) ? 2 : CONFIG_LOAD_DELAY_CYC_RAW;
    localparam int MIN_REFRESH = 2;
    // Link address widths
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int PRECHARGE_ALL_BIT = 10;
    // Configuration word field positions
    localparam int SPAN_LSB = 0;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int OPMODE_LSB = 7;
    localparam int WBURST_BIT = 9;
    localparam int RSVD_LSB = 10;
    // Field codes
    localparam logic [2:0] SPAN_1 = 3'h0;
    localparam logic [2:0] SPAN_2 = 3'h1;
    localparam logic [2:0] SPAN_4 = 3'h2;
    localparam logic [2:0] SPAN_8 = 3'h3;
    localparam logic [2:0] SPAN_FULL = 3'h7;
    localparam logic [2:0] LAT_2 = 3'h2;
    localparam logic [2:0] LAT_3 = 3'h3;
    localparam logic [12:0] CONFIG_RESET = 13'h0000;
    // Controller register byte offsets and reset values
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_WDATA = 8'h14;
    localparam logic [3:0] REFRESH_COUNT_RESET = 4'h2;
    localparam logic [12:0] MODE_REG_RESET = 13'h0032;
    // Link commands as {row strobe, column strobe, write enable}
    typedef enum logic [2:0] {
        CMD_LOAD = 3'h0,
        CMD_REFRESH = 3'h1,
        CMD_PRECHARGE = 3'h2,
        CMD_ACTIVE = 3'h3,
        CMD_WRITE = 3'h4,
        CMD_READ = 3'h5,
        CMD_TERMINATE = 3'h6,
        CMD_NOP = 3'h7
    } sic_cmd_t;
    // Controller sequence states
    typedef enum logic [2:0] {
        ST_POWERUP = 3'h0,
        ST_PRECHARGE = 3'h1,
        ST_WAIT_RP = 3'h2,
        ST_REFRESH = 3'h3,
        ST_WAIT_RFC = 3'h4,
        ST_LOAD = 3'h5,
        ST_WAIT_MRD = 3'h6,
        ST_READY = 3'h7
    } sic_state_t;
endpackage

/* File: src/sic_link_if.sv */
// Command, address and data link between controller and memory device
`timescale 1ns/1ps
interface sic_link_if #(parameter int DQ_W = 16) (input logic clock);
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [sic_pkg::BA_W-1:0] ba;
    logic [sic_pkg::ADDR_W-1:0] addr;
    logic [DQ_W-1:0] ctrlDq;
    logic ctrlDqOe;
    logic [DQ_W-1:0] memDq;
    logic memDqOe;
    modport ctrl (input clock, output cke, csN, rasN, casN, weN, ba, addr, ctrlDq, ctrlDqOe,
                  input memDq, memDqOe);
    modport mem (input clock, input cke, csN, rasN, casN, weN, ba, addr, ctrlDq, ctrlDqOe,
                 output memDq, memDqOe);
endinterface

/* File: src/sic_sdram_device.sv */
// Memory end: configuration word, burst column order, read latency and one open page
`timescale 1ns/1ps
module sic_sdram_device #(
    parameter int DQ_W = 16,
    parameter int PAGE_COLS = 512
) (
    input wire logic clock, // System clock
    input wire logic resetn, // Synchronous reset, active low
    sic_link_if.mem link, // Link from the controller
    output logic [12:0] configWord, // Stored configuration word
    output logic configLoaded, // A load has been taken since reset
    output logic burstActive, // Burst engine still stepping
    output logic badMode, // Reserved mode or latency code stored
    output logic earlyCommand, // Operational command seen before any load
    output logic [3:0] refreshSeen // Refresh commands seen, saturating
);
    localparam int COL_W = $clog2(PAGE_COLS);

    logic [DQ_W-1:0] pageMem [PAGE_COLS];
    sic_pkg::sic_cmd_t cmd;
    logic rwStart;
    logic opNormal;
    logic lat3;
    logic [2:0] spanCode;
    logic [COL_W-1:0] newMask;
    logic newWrite;
    logic newInterleave;
    logic active;
    logic burstWrite;
    logic burstInterleave;
    logic [COL_W-1:0] startCol;
    logic [COL_W-1:0] beat;
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] curStart;
    logic [COL_W-1:0] curBeat;
    logic [COL_W-1:0] curMask;
    logic curWrite;
    logic curInterleave;
    logic [COL_W-1:0] curCol;
    logic doBeat;
    logic stage0Valid;
    logic stage1Valid;
    logic [COL_W-1:0] stage0Col;
    logic [COL_W-1:0] stage1Col;
    logic selValid;
    logic [COL_W-1:0] selCol;

    // Low-bit mask of the wrap block for a span code
    function automatic logic [COL_W-1:0] spanMask(input logic [2:0] code);
        logic [COL_W-1:0] m;
        m = '0;
        unique case (code)
            sic_pkg::SPAN_2: m = COL_W'(1);
            sic_pkg::SPAN_4: m = COL_W'(3);
            sic_pkg::SPAN_8: m = COL_W'(7);
            sic_pkg::SPAN_FULL: m = '1;
            default: m = '0; // Span one and reserved codes act as one location
        endcase
        return m;
    endfunction

    // Column of one beat: block bits kept, low bits stepped and wrapped
    function automatic logic [COL_W-1:0] beatCol(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] step,
                                                 input logic [COL_W-1:0] m,
                                                 input logic interleave);
        logic [COL_W-1:0] low;
        low = interleave ? (start ^ step) : COL_W'(start + step);
        return (start & ~m) | (low & m);
    endfunction

    // Decode the link; a low clock gate or a high select means NOP
    always_comb begin
        cmd = sic_pkg::CMD_NOP;
        if (link.cke && !link.csN) begin
            cmd = sic_pkg::sic_cmd_t'({link.rasN, link.casN, link.weN});
        end
    end

    // Field decode of the stored word
    assign spanCode = configWord[sic_pkg::SPAN_LSB +: 3];
    assign opNormal = (configWord[sic_pkg::OPMODE_LSB +: 2] == 2'h0);
    assign lat3 = (configWord[sic_pkg::LAT_LSB +: 3] != sic_pkg::LAT_2);
    assign badMode = !opNormal ||
        ((configWord[sic_pkg::LAT_LSB +: 3] != sic_pkg::LAT_2) &&
         (configWord[sic_pkg::LAT_LSB +: 3] != sic_pkg::LAT_3));

    // Reserved operating modes keep bursts from starting
    assign rwStart = ((cmd == sic_pkg::CMD_READ) || (cmd == sic_pkg::CMD_WRITE)) && opNormal;
    assign newWrite = (cmd == sic_pkg::CMD_WRITE);
    // Writes shrink to one location when the write-burst bit is set
    assign newMask = (newWrite && configWord[sic_pkg::WBURST_BIT]) ? '0 : spanMask(spanCode);
    // Full page never interleaves; span one has an empty mask so order is moot
    assign newInterleave = configWord[sic_pkg::ORDER_BIT] &&
        (spanCode != sic_pkg::SPAN_FULL);

    // Current beat: a new command restarts at beat zero in its own cycle
    always_comb begin
        curStart = startCol;
        curBeat = beat;
        curMask = mask;
        curWrite = burstWrite;
        curInterleave = burstInterleave;
        if (rwStart) begin
            curStart = link.addr[COL_W-1:0];
            curBeat = '0;
            curMask = newMask;
            curWrite = newWrite;
            curInterleave = newInterleave;
        end
    end
    assign curCol = beatCol(curStart, curBeat, curMask, curInterleave);
    // Terminate cancels the beat of its own edge
    assign doBeat = rwStart || (active && (cmd != sic_pkg::CMD_TERMINATE));
    assign burstActive = active;

    // Burst engine; a full page keeps wrapping until cut or replaced
    always_ff @(posedge clock) begin
        if (!resetn) begin
            active <= 1'b0;
            burstWrite <= 1'b0;
            burstInterleave <= 1'b0;
            startCol <= '0;
            beat <= '0;
            mask <= '0;
        end else if (rwStart) begin
            active <= (newMask != '0);
            burstWrite <= newWrite;
            burstInterleave <= newInterleave;
            startCol <= link.addr[COL_W-1:0];
            beat <= COL_W'(1);
            mask <= newMask;
        end else if (active) begin
            if ((cmd == sic_pkg::CMD_TERMINATE) || (cmd == sic_pkg::CMD_LOAD)) begin
                active <= 1'b0;
            end else begin
                beat <= COL_W'(beat + COL_W'(1));
                if ((beat == mask) && (mask != '1)) begin
                    active <= 1'b0; // fixed spans stop after the last beat
                end
            end
        end
    end

    // Write beats land in the same edge as their column
    always_ff @(posedge clock) begin
        if (doBeat && curWrite) begin
            pageMem[curCol] <= link.ctrlDq;
        end
    end

    // Read pipeline; a load empties it so the outputs go idle
    always_ff @(posedge clock) begin
        if (!resetn || (cmd == sic_pkg::CMD_LOAD)) begin
            stage0Valid <= 1'b0;
            stage1Valid <= 1'b0;
            stage0Col <= '0;
            stage1Col <= '0;
        end else begin
            stage0Valid <= doBeat && !curWrite;
            stage0Col <= curCol;
            stage1Valid <= stage0Valid;
            stage1Col <= stage0Col;
        end
    end
    // Latency two reads the first stage, three the second
    assign selValid = lat3 ? stage1Valid : stage0Valid;
    assign selCol = lat3 ? stage1Col : stage0Col;

    // Output drive starts at edge n+m-1 and holds each word one cycle
    always_ff @(posedge clock) begin
        if (!resetn || (cmd == sic_pkg::CMD_LOAD)) begin
            link.memDq <= '0;
            link.memDqOe <= 1'b0;
        end else begin
            link.memDq <= selValid ? pageMem[selCol] : '0;
            link.memDqOe <= selValid;
        end
    end

    // Configuration load needs both bank bits low; other loads are dropped
    always_ff @(posedge clock) begin
        if (!resetn) begin
            configWord <= sic_pkg::CONFIG_RESET; // stand-in for the unknown power-up word
            configLoaded <= 1'b0;
        end else if ((cmd == sic_pkg::CMD_LOAD) && (link.ba == 2'h0)) begin
            configWord <= link.addr;
            configLoaded <= 1'b1;
        end
    end

    // Sequence watch, useful for spotting a controller that skipped the load
    always_ff @(posedge clock) begin
        if (!resetn) begin
            earlyCommand <= 1'b0;
            refreshSeen <= 4'h0;
        end else begin
            if (!configLoaded && ((cmd == sic_pkg::CMD_ACTIVE) ||
                (cmd == sic_pkg::CMD_READ) || (cmd == sic_pkg::CMD_WRITE))) begin
                earlyCommand <= 1'b1;
            end
            if ((cmd == sic_pkg::CMD_REFRESH) && (refreshSeen != 4'hF)) begin
                refreshSeen <= refreshSeen + 4'h1;
            end
        end
    end
endmodule

/* File: src/sic_sdram_ctrl.sv */
// Controller end: power-up sequence, configuration load and raw commands under APB
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module sic_sdram_ctrl #(
    parameter int DQ_W = 16,
    parameter int POWERUP_CYCLES = sic_pkg::POWERUP_CYCLES
) (
    input wire logic clock, // System clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [7:0] paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready, always high
    output logic pslverr, // APB error on unmapped address
    sic_link_if.ctrl link, // Link to the memory
    output logic memReady // Sequence finished
);
    sic_pkg::sic_state_t state;
    logic [31:0] cnt;
    logic [3:0] refDone;
    logic loaded;
    logic loadFirst;
    logic [3:0] refCount;
    logic [3:0] refTarget;
    logic [12:0] modeWord;
    logic [17:0] rawCmd;
    logic rawPending;
    logic reloadReq;
    logic [DQ_W-1:0] wdata;
    logic [DQ_W-1:0] rdata;
    logic apbWrite;
    logic mapped;

    assign apbWrite = psel && penable && pwrite;
    assign mapped = (paddr == sic_pkg::REG_CTRL) || (paddr == sic_pkg::REG_MODE) ||
        (paddr == sic_pkg::REG_STATUS) || (paddr == sic_pkg::REG_CMD) ||
        (paddr == sic_pkg::REG_RDATA) || (paddr == sic_pkg::REG_WDATA);
    // Fewer than two refreshes is never allowed
    assign refTarget = (refCount < 4'(sic_pkg::MIN_REFRESH)) ? 4'(sic_pkg::MIN_REFRESH) : refCount;
    assign memReady = (state == sic_pkg::ST_READY);

    // Register writes; reload and raw commands only act once ready
    always_ff @(posedge clock) begin
        if (!resetn) begin
            loadFirst <= 1'b0;
            refCount <= sic_pkg::REFRESH_COUNT_RESET;
            modeWord <= sic_pkg::MODE_REG_RESET;
            rawCmd <= 18'h00000;
            rawPending <= 1'b0;
            reloadReq <= 1'b0;
            wdata <= '0;
        end else begin
            rawPending <= 1'b0;
            reloadReq <= reloadReq && (state != sic_pkg::ST_LOAD);
            if (apbWrite && (paddr == sic_pkg::REG_CTRL)) begin
                loadFirst <= pwdata[1];
                refCount <= pwdata[7:4];
                reloadReq <= pwdata[0] && memReady;
            end
            if (apbWrite && (paddr == sic_pkg::REG_MODE)) begin
                modeWord <= pwdata[12:0];
            end
            if (apbWrite && (paddr == sic_pkg::REG_CMD) && memReady) begin
                rawCmd <= pwdata[17:0];
                rawPending <= 1'b1;
            end
            if (apbWrite && (paddr == sic_pkg::REG_WDATA)) begin
                wdata <= pwdata[DQ_W-1:0];
            end
        end
    end

    // Zero-wait slave; reads are combinational from registers
    always_comb begin
        pready = 1'b1;
        pslverr = psel && penable && !mapped;
        prdata = 32'h00000000;
        unique case (paddr)
            sic_pkg::REG_CTRL: prdata = {24'h000000, refCount, 2'h0, loadFirst, 1'b0};
            sic_pkg::REG_MODE: prdata = {19'h00000, modeWord};
            sic_pkg::REG_STATUS: prdata = {22'h000000, refDone, 1'b0, state, link.cke, memReady};
            sic_pkg::REG_CMD: prdata = {14'h0000, rawCmd};
            sic_pkg::REG_RDATA: prdata = 32'(rdata);
            sic_pkg::REG_WDATA: prdata = 32'(wdata);
            default: prdata = 32'h00000000;
        endcase
    end

    // Power-up sequence; the start-up wait lasts its full count, each wait after a command the wait in cycles minus one
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= sic_pkg::ST_POWERUP;
            cnt <= 32'h00000000;
            refDone <= 4'h0;
            loaded <= 1'b0;
        end else begin
            unique case (state)
                sic_pkg::ST_POWERUP: begin
                    cnt <= cnt + 32'h00000001;
                    if (cnt == 32'(POWERUP_CYCLES - 1)) begin
                        state <= sic_pkg::ST_PRECHARGE;
                    end
                end
                sic_pkg::ST_PRECHARGE: begin
                    cnt <= 32'h00000000;
                    state <= sic_pkg::ST_WAIT_RP;
                end
                sic_pkg::ST_WAIT_RP: begin
                    cnt <= cnt + 32'h00000001;
                    if (cnt == 32'(sic_pkg::TRP_CYC - 2)) begin
                        state <= loadFirst ? sic_pkg::ST_LOAD : sic_pkg::ST_REFRESH;
                    end
                end
                sic_pkg::ST_REFRESH: begin
                    cnt <= 32'h00000000;
                    refDone <= refDone + 4'h1;
                    state <= sic_pkg::ST_WAIT_RFC;
                end
                sic_pkg::ST_WAIT_RFC: begin
                    cnt <= cnt + 32'h00000001;
                    if (cnt == 32'(sic_pkg::REFRESH_CYCLE_TIME_CYC - 2)) begin
                        if (refDone < refTarget) begin
                            state <= sic_pkg::ST_REFRESH;
                        end else begin
                            state <= loaded ? sic_pkg::ST_READY : sic_pkg::ST_LOAD;
                        end
                    end
                end
                sic_pkg::ST_LOAD: begin
                    cnt <= 32'h00000000;
                    loaded <= 1'b1;
                    state <= sic_pkg::ST_WAIT_MRD;
                end
                sic_pkg::ST_WAIT_MRD: begin
                    cnt <= cnt + 32'h00000001;
                    if (cnt == 32'(sic_pkg::CONFIG_LOAD_DELAY_CYC - 2)) begin
                        state <= (refDone < refTarget) ? sic_pkg::ST_REFRESH :
                            sic_pkg::ST_READY;
                    end
                end
                sic_pkg::ST_READY: begin
                    if (reloadReq) begin
                        state <= sic_pkg::ST_LOAD; // Banks must be idle, software's duty
                    end
                end
            endcase
        end
    end

    // Link drive: one cycle behind the state, so every spacing is kept
    always_ff @(posedge clock) begin
        if (!resetn) begin
            link.cke <= 1'b0;
            link.csN <= 1'b1; // inhibit while held in reset
            {link.rasN, link.casN, link.weN} <= sic_pkg::CMD_NOP;
            link.ba <= 2'h0;
            link.addr <= 13'h0000;
            link.ctrlDq <= '0;
            link.ctrlDqOe <= 1'b0;
        end else begin
            // Clock gate rises halfway through the start-up wait
            if ((state == sic_pkg::ST_POWERUP) && (cnt == 32'(POWERUP_CYCLES / 2))) begin
                link.cke <= 1'b1;
            end
            link.csN <= 1'b0;
            {link.rasN, link.casN, link.weN} <= sic_pkg::CMD_NOP;
            link.ba <= 2'h0;
            link.addr <= 13'h0000;
            link.ctrlDqOe <= 1'b0;
            unique case (state)
                sic_pkg::ST_PRECHARGE: begin
                    {link.rasN, link.casN, link.weN} <= sic_pkg::CMD_PRECHARGE;
                    link.addr <= 13'(1 << sic_pkg::PRECHARGE_ALL_BIT);
                end
                sic_pkg::ST_REFRESH: begin
                    {link.rasN, link.casN, link.weN} <= sic_pkg::CMD_REFRESH;
                end
                sic_pkg::ST_LOAD: begin
                    {link.rasN, link.casN, link.weN} <= sic_pkg::CMD_LOAD;
                    link.addr <= {3'h0, modeWord[sic_pkg::RSVD_LSB-1:0]};
                end
                sic_pkg::ST_READY: begin
                    if (rawPending) begin
                        {link.rasN, link.casN, link.weN} <= rawCmd[17:15];
                        link.ba <= rawCmd[14:13];
                        link.addr <= rawCmd[12:0];
                        link.ctrlDq <= wdata;
                        link.ctrlDqOe <= (rawCmd[17:15] == sic_pkg::CMD_WRITE);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Last word the memory drove
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (link.memDqOe) begin
            rdata <= link.memDq;
        end
    end
endmodule

/* File: tb/sic_properties.sv */
// Assertions on the link between controller and memory
`timescale 1ns/1ps
module sic_properties #(parameter int POWERUP_CYCLES = 40) (
    input wire logic clock, // Clock
    input wire logic resetn, // Reset
    input wire logic cke, // Gate
    input wire logic csN, // Select
    input wire logic rasN, // Row
    input wire logic casN, // Column
    input wire logic weN, // Write
    input wire logic [1:0] ba, // Banks
    input wire logic [12:0] addr, // Address
    input wire logic memDqOe // Drive
);
    logic [15:0] cnt;
    logic [2:0] latCode;
    logic [2:0] cmd;
    logic idle;
    // A deselected device sees no command at all
    assign cmd = {rasN, casN, weN};
    assign idle = csN || cmd == 3'h7;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Saturates, so a long run never wraps back into the start-up window
    always_ff @(posedge clock) begin
        if (!resetn) cnt <= 16'h0000;
        else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
    end
    // Latency of the last accepted load; the zero reset code acts as three
    always_ff @(posedge clock) begin
        if (!resetn) latCode <= 3'h0;
        else if (!idle && cmd == 3'h0 && ba == 2'h0) latCode <= addr[6:4];
    end
    sequence s_rp_gap; idle [*3]; endsequence
    sequence s_rfc_gap; idle [*8] ##1 idle [*5]; endsequence
    sequence s_load_gap; idle && !memDqOe; endsequence
    a_startup_quiet: assert property (cnt < POWERUP_CYCLES |-> idle)
        else $error("command in start-up wait");
    a_cke_low_start: assert property (cnt < 2 |-> !cke)
        else $error("gate high at power-up");
    a_cke_before_cmd: assert property (!idle |-> cke)
        else $error("command with gate low");
    a_precharge_all: assert property (!idle && cmd == 3'h2 |-> addr[10])
        else $error("precharge not all banks");
    a_rp_wait: assert property (!idle && cmd == 3'h2 |=> s_rp_gap)
        else $error("precharge wait short");
    a_rfc_wait: assert property (!idle && cmd == 3'h1 |=> s_rfc_gap)
        else $error("refresh wait short");
    a_load_fields: assert property (!idle && cmd == 3'h0 |-> ba == 2'h0 && addr[12:10] == 3'h0)
        else $error("load word or banks wrong");
    a_load_delay: assert property (!idle && cmd == 3'h0 |=> s_load_gap)
        else $error("load delay or outputs wrong");
    a_read_latency: assert property (!idle && cmd == 3'h5 |->
        if (latCode == 3'h2) ##2 memDqOe else ##3 memDqOe) else $error("read latency wrong");
endmodule

/* File: tb/tb.sv */
// Testbench joining controller and memory ends over the link
`timescale 1ns/1ps
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin failCount++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
    logic clock, resetn, psel, penable, pwrite, pready, pslverr, memReady, err;
    logic configLoaded, burstActive, badMode, earlyCommand;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] configWord;
    logic [3:0] refreshSeen;
    int failCount = 0;
    int cmpCount = 0;
    sic_link_if link (.clock(clock));
    sic_sdram_ctrl #(.POWERUP_CYCLES(40)) sic_sdram_ctrl_inst (.clock, .resetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .link, .memReady);
    sic_sdram_device sic_sdram_device_inst (.clock, .resetn, .link, .configWord, .configLoaded,
        .burstActive, .badMode, .earlyCommand, .refreshSeen);
    sic_properties #(.POWERUP_CYCLES(40)) sic_properties_inst (.clock, .resetn, .cke(link.cke),
        .csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN), .ba(link.ba),
        .addr(link.addr), .memDqOe(link.memDqOe));
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // One APB transfer; an idle edge after it keeps the next setup apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_ready();
        for (int n = 0; n < 400 && memReady !== 1'b1; n++) @(posedge clock);
        `CHK(memReady, 1'b1)
    endtask
    // Load a word, issue one read, maybe cut it after three beats, and collect every beat
    task automatic burst(input logic ord, input logic [2:0] lat, input logic [2:0] span,
        input logic [8:0] s, input logic cut);
        logic [15:0] q[$];
        logic [12:0] m;
        int n;
        int w;
        int c;
        n = cut ? 3 : 1 << span;
        w = cut ? 512 : n;
        m = {3'h0, 1'b1, 2'h0, lat, ord, span};
        apb(1'b1, 8'h04, {19'h0, m});
        apb(1'b1, 8'h00, 32'h00000031);
        repeat (6) @(posedge clock);
        wait_ready();
        `CHK(configWord, m)
        apb(1'b1, 8'h0C, 32'h00028000 | s);
        // Terminate lands three edges after the read does, so three beats run
        if (cut) apb(1'b1, 8'h0C, 32'h00030000);
        repeat (16) begin
            @(posedge clock);
            if (link.memDqOe === 1'b1) q.push_back(link.memDq);
        end
        `CHK(q.size(), n)
        for (int k = 0; k < n; k++) begin
            // Full page wraps at the page and never interleaves
            c = (s & ~(w - 1)) | (((ord && !cut) ? s ^ k : s + k) & (w - 1));
            `CHK(q[k], 16'h0010 + c[15:0])
        end
        `CHK(burstActive, 1'b0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h00000010 + c)
        $display("burst test done, length %0d", n);
    endtask
    task automatic printVerdict();
        $display("comparisons %0d, mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Whole run is a few hundred cycles; this limit is far beyond it
    initial begin
        #100000;
        failCount++;
        printVerdict();
    end
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h00000032)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 8'h04, 32'h00000232);
        apb(1'b1, 8'h00, 32'h00000030);
        wait_ready();
        `CHK(configWord, 13'h0232)
        `CHK(refreshSeen, 4'h3)
        `CHK({configLoaded, earlyCommand, badMode}, 3'b100)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h000000DF)
        $display("init test done");
        // Single-location writes fill columns 0 to 7 with known data
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h14, 32'h00000010 + c);
            apb(1'b1, 8'h0C, 32'h00020000 | c);
            repeat (3) @(posedge clock);
        end
        burst(1'b0, 3'h3, 3'h2, 9'h001, 1'b0);
        burst(1'b1, 3'h2, 3'h2, 9'h001, 1'b0);
        burst(1'b1, 3'h3, 3'h3, 9'h005, 1'b0);
        burst(1'b0, 3'h2, 3'h1, 9'h007, 1'b0);
        burst(1'b1, 3'h2, 3'h0, 9'h003, 1'b0);
        burst(1'b1, 3'h3, 3'h7, 9'h005, 1'b1);
        // Reserved operating mode is stored but flagged; no read follows it
        apb(1'b1, 8'h04, 32'h000000B2);
        apb(1'b1, 8'h00, 32'h00000031);
        repeat (6) @(posedge clock);
        wait_ready();
        `CHK(badMode, 1'b1)
        $display("mode test done");
        printVerdict();
    end
endmodule
